// File: rtl/cpt_cfg.svh
`ifndef CPT_CFG_SVH
`define CPT_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CPT_OFS_CARRIER_MODE  8'h00
`define CPT_OFS_CMP_A         8'h04
`define CPT_OFS_CMP_B         8'h08
`define CPT_OFS_CARRIER_CTRL  8'h0C
`define CPT_OFS_PACE_MODE     8'h10
`define CPT_OFS_PACE_CLK      8'h14
`define CPT_OFS_PACE_CMP      8'h18
`define CPT_OFS_PACE_COUNT    8'h1C
`define CPT_OFS_EVT0_MODE     8'h20
`define CPT_OFS_EVT0_CLK      8'h24
`define CPT_OFS_EVT0_CMP      8'h28
`define CPT_OFS_EVT0_COUNT    8'h2C
`define CPT_OFS_IRQ_STATUS    8'h30
`define CPT_OFS_IRQ_ENABLE    8'h34
`define CPT_OFS_IRQ_CLEAR     8'h38

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CPT_BIT_ENABLE        7
`define CPT_BIT_PWM           6
`define CPT_BIT_LVS           3
`define CPT_BIT_LVR           2
`define CPT_BIT_ALVL          1
`define CPT_BIT_TOE           0
`define CPT_BIT_GATE_BUF      0
`define CPT_BIT_GATE          1
`define CPT_BIT_REMOTE_EN     2
`define CPT_IRQ_CARRIER       0
`define CPT_IRQ_PACE          1
`define CPT_IRQ_STROBE        2
`define CPT_IRQ_EVT0          3

// ----------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------
`define CPT_RST_BYTE          8'h00
`define CPT_RST_CMP           8'hFF
`define CPT_IRQ_BITS          4
`define CPT_PRESCALE_BITS     8

`endif

// File: rtl/cpt_pkg.sv
package cpt_pkg;

  // settings of one 8-bit event counter
  typedef struct packed {
    logic       enable;
    logic       pwm;
    logic       active_low;
    logic       toe;
    logic [2:0] clk_sel;
    logic [7:0] cmp;
  } cpt_evt_cfg_t;

  // avalon request as seen by the slave
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } cpt_bus_req_t;

  typedef enum logic [1:0] {
    CPT_BUS_IDLE = 2'b01,
    CPT_BUS_ACK  = 2'b10
  } cpt_bus_state_t;

  // count clock tick: select k divides the system clock by 2**k
  function automatic logic cpt_tick(input logic [7:0] pre,
                                    input logic [2:0] sel);
    logic [7:0] mask;
    mask = 8'((9'h001 << sel) - 9'h001);
    return (pre & mask) == mask;
  endfunction

endpackage

// File: rtl/cpt_event_counter.sv
`timescale 1ns/1ps
`include "cpt_cfg.svh"

module cpt_event_counter
  import cpt_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire cpt_evt_cfg_t cfg,
  input  wire logic [7:0]   prescale,
  input  wire logic         level_set,
  input  wire logic         level_clr,
  output logic [7:0]        count,
  output logic              match,
  output logic              pin
);

  logic       tick;
  logic [7:0] cmp_active;
  logic       hit;

  assign tick = cfg.enable & cpt_tick(prescale, cfg.clk_sel); // RL13
  assign hit  = cfg.pwm ? (count == 8'hFF) : (count == cfg.cmp);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n || !cfg.enable)
      count <= 8'h00;
    else if (tick)
      count <= hit ? 8'h00 : 8'(count + 8'h01);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      match <= 1'b0;
    else
      match <= tick & hit;
  end

  // pwm compare reloads only at wrap or while disabled, so a rewrite followed by
  // another before the next wrap (one wrap per 256 count clocks) is lost
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmp_active <= `CPT_RST_CMP;
    else if (!cfg.enable || (tick && hit))
      cmp_active <= cfg.cmp; // RL15
  end

  // ----------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pin <= 1'b0;
    else if (level_set)
      pin <= 1'b1; // RL16
    else if (level_clr)
      pin <= 1'b0; // RL16
    else if (cfg.enable && cfg.toe && cfg.pwm) // RL11 RL14
      pin <= (count < cmp_active) ^ cfg.active_low; // RL12
    else if (cfg.enable && cfg.toe && tick && hit)
      pin <= ~pin;
  end

endmodule

// File: rtl/cpt_top.sv
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cpt_cfg.svh"

// Notes on behaviour
// RL1 - carrier timer counts once its enable set
// RL2 - pacing counter runs while its enable set
// RL3 - first compare after enable uses register A
// RL4 - match A: irq, clear, switch to B
// RL5 - match B: irq, clear, back to A
// RL6 - pacing match resynced to carrier count clock
// RL7 - each strobe copies gate buffer to gate
// RL8 - software refills buffer and compare per strobe
// RL9 - gate high passes carrier to output pin
// RL10 - software sets remote enable and gate buffer
// RL11 - mode bit 6 selects pwm operation
// RL12 - pulse width equals compare; bit 1 polarity
// RL13 - bits 0 to 2 select count clock
// RL14 - mode bit 0 enables pwm pin output
// RL15 - compare rewrites spaced three count clocks (pwm compare here reloads only at wrap, once per 256 count clocks, or while disabled)
// RL16 - bits 2 and 3 force pin level
// RL17 - gate low holds carrier pin inactive
module cpt_top
  import cpt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             carrier_output_pin,
  output logic             pacing_output_pin,
  output logic             event_timer_output_pin,
  output logic             irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cpt_bus_req_t   req;
  cpt_bus_state_t bus_state;
  logic           wr_fire;
  logic [31:0]    next_readdata;
  logic [7:0]     prescale;
  logic           carrier_timer_enable, remote_output_enable, use_b;
  logic           carrier_gate_buffer_bit, carrier_gate_bit;
  logic           carrier_tick, carrier_hit, carrier_match_irq;
  logic [2:0]     carrier_clk_sel, pacing_clock_select;
  logic [7:0]     compare_register_a, compare_register_b, carrier_count;
  logic [7:0]     pacing_mode_control, pacing_compare_register, pacing_count;
  logic           pacing_match_irq, strobe_pending, synced_data_strobe;
  logic [7:0]     event_timer_mode_control, event_timer_compare, evt0_count;
  logic [2:0]     count_clock_select_register;
  logic           evt0_match, pace_lvs, pace_lvr, evt0_lvs, evt0_lvr;
  logic [`CPT_IRQ_BITS-1:0] irq_status, irq_enable, irq_events;
  logic [`CPT_IRQ_BITS-1:0] irq_clear, next_irq_status;
  cpt_evt_cfg_t   pacing_cfg, evt0_cfg;

  function automatic cpt_evt_cfg_t make_cfg(input logic [7:0] mode,
                                            input logic [2:0] sel,
                                            input logic [7:0] cmp);
    return '{enable: mode[`CPT_BIT_ENABLE], pwm: mode[`CPT_BIT_PWM],
             active_low: mode[`CPT_BIT_ALVL], toe: mode[`CPT_BIT_TOE],
             clk_sel: sel, cmp: cmp};
  endfunction

  function automatic logic wr_to(input cpt_bus_req_t r,
                                 input logic [7:0] ofs);
    return r.write && (r.address == ofs);
  endfunction

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  assign req.address   = avs_address;
  assign req.read      = avs_read;
  assign req.write     = avs_write;
  assign req.writedata = avs_writedata;

  // writes land only at the edge that sees waitrequest low
  assign wr_fire = (bus_state == CPT_BUS_ACK) && req.write;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bus_state <= CPT_BUS_IDLE;
    else
      case (bus_state)
        CPT_BUS_IDLE:
          if (req.read || req.write)
            bus_state <= CPT_BUS_ACK;
        default:
          bus_state <= CPT_BUS_IDLE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((bus_state == CPT_BUS_IDLE) &&
                           (req.read || req.write));
  end
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (req.address)
      `CPT_OFS_CARRIER_MODE:
      begin
        next_readdata[`CPT_BIT_ENABLE] = carrier_timer_enable;
        next_readdata[2:0]             = carrier_clk_sel;
      end
      `CPT_OFS_CMP_A:      next_readdata[7:0] = compare_register_a;
      `CPT_OFS_CMP_B:      next_readdata[7:0] = compare_register_b;
      `CPT_OFS_CARRIER_CTRL:
      begin
        next_readdata[`CPT_BIT_GATE_BUF]  = carrier_gate_buffer_bit;
        next_readdata[`CPT_BIT_GATE]      = carrier_gate_bit;
        next_readdata[`CPT_BIT_REMOTE_EN] = remote_output_enable;
      end
      `CPT_OFS_PACE_MODE:  next_readdata[7:0] = pacing_mode_control;
      `CPT_OFS_PACE_CLK:   next_readdata[2:0] = pacing_clock_select;
      `CPT_OFS_PACE_CMP:   next_readdata[7:0] = pacing_compare_register;
      `CPT_OFS_PACE_COUNT: next_readdata[7:0] = pacing_count;
      `CPT_OFS_EVT0_MODE:  next_readdata[7:0] = event_timer_mode_control;
      `CPT_OFS_EVT0_CLK:   next_readdata[2:0] = count_clock_select_register;
      `CPT_OFS_EVT0_CMP:   next_readdata[7:0] = event_timer_compare;
      `CPT_OFS_EVT0_COUNT: next_readdata[7:0] = evt0_count;
      `CPT_OFS_IRQ_STATUS: next_readdata[`CPT_IRQ_BITS-1:0] = irq_status;
      `CPT_OFS_IRQ_ENABLE: next_readdata[`CPT_IRQ_BITS-1:0] = irq_enable;
      default:             next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if ((bus_state == CPT_BUS_IDLE) && req.read)
      avs_readdata <= next_readdata;
  end
  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      carrier_timer_enable <= 1'b0;
      carrier_clk_sel      <= 3'h0;
      compare_register_a   <= `CPT_RST_CMP;
      compare_register_b   <= `CPT_RST_CMP;
    end
    else if (wr_fire)
    begin
      if (wr_to(req, `CPT_OFS_CARRIER_MODE))
      begin
        carrier_timer_enable <= req.writedata[`CPT_BIT_ENABLE];
        carrier_clk_sel      <= req.writedata[2:0];
      end
      if (wr_to(req, `CPT_OFS_CMP_A))
        compare_register_a <= req.writedata[7:0];
      if (wr_to(req, `CPT_OFS_CMP_B))
        compare_register_b <= req.writedata[7:0];
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      remote_output_enable    <= 1'b0;
      carrier_gate_buffer_bit <= 1'b0;
    end
    else if (wr_fire && wr_to(req, `CPT_OFS_CARRIER_CTRL))
    begin
      remote_output_enable    <= req.writedata[`CPT_BIT_REMOTE_EN];
      carrier_gate_buffer_bit <= req.writedata[`CPT_BIT_GATE_BUF]; // RL8
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pacing_mode_control         <= `CPT_RST_BYTE;
      pacing_clock_select         <= 3'h0;
      pacing_compare_register     <= `CPT_RST_CMP;
      event_timer_mode_control    <= `CPT_RST_BYTE;
      count_clock_select_register <= 3'h0;
      event_timer_compare         <= `CPT_RST_CMP;
    end
    else if (wr_fire)
    begin
      if (wr_to(req, `CPT_OFS_PACE_MODE))
        pacing_mode_control <= req.writedata[7:0];
      if (wr_to(req, `CPT_OFS_PACE_CLK))
        pacing_clock_select <= req.writedata[2:0];
      if (wr_to(req, `CPT_OFS_PACE_CMP))
        pacing_compare_register <= req.writedata[7:0];
      if (wr_to(req, `CPT_OFS_EVT0_MODE))
        event_timer_mode_control <= req.writedata[7:0];
      if (wr_to(req, `CPT_OFS_EVT0_CLK))
        count_clock_select_register <= req.writedata[2:0];
      if (wr_to(req, `CPT_OFS_EVT0_CMP))
        event_timer_compare <= req.writedata[7:0];
    end
  end

  // level forcing acts as a one-shot on the mode write
  assign pace_lvs = wr_fire && wr_to(req, `CPT_OFS_PACE_MODE) &&
                    req.writedata[`CPT_BIT_LVS];
  assign pace_lvr = wr_fire && wr_to(req, `CPT_OFS_PACE_MODE) &&
                    req.writedata[`CPT_BIT_LVR];
  assign evt0_lvs = wr_fire && wr_to(req, `CPT_OFS_EVT0_MODE) &&
                    req.writedata[`CPT_BIT_LVS];
  assign evt0_lvr = wr_fire && wr_to(req, `CPT_OFS_EVT0_MODE) &&
                    req.writedata[`CPT_BIT_LVR];

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prescale <= 8'h00;
    else
      prescale <= 8'(prescale + 8'h01);
  end

  // ----------------------------------------------------------------
  // carrier timer
  // ----------------------------------------------------------------
  assign carrier_tick = carrier_timer_enable &&
                        cpt_tick(prescale, carrier_clk_sel); // RL1
  assign carrier_hit  = carrier_count ==
                        (use_b ? compare_register_b : compare_register_a);

  always_ff @(posedge clk)
  begin
    if (!rst_n || !carrier_timer_enable)
      carrier_count <= 8'h00;
    else if (carrier_tick)
      carrier_count <= carrier_hit ? 8'h00 : 8'(carrier_count + 8'h01);
  end
  // disabling returns to register A so every start compares A first
  always_ff @(posedge clk)
  begin
    if (!rst_n || !carrier_timer_enable)
      use_b <= 1'b0; // RL3
    else if (carrier_tick && carrier_hit)
      use_b <= ~use_b; // RL4 RL5
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      carrier_match_irq <= 1'b0;
    else
      carrier_match_irq <= carrier_tick && carrier_hit; // RL4 RL5
  end
  // ----------------------------------------------------------------
  // data strobe resync and gate
  // ----------------------------------------------------------------
  // a pacing match waits for the next carrier count clock tick
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      strobe_pending <= 1'b0;
    else if (pacing_match_irq)
      strobe_pending <= 1'b1;
    else if (carrier_tick)
      strobe_pending <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      synced_data_strobe <= 1'b0;
    else
      synced_data_strobe <= strobe_pending && carrier_tick; // RL6
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      carrier_gate_bit <= 1'b0;
    else if (synced_data_strobe)
      carrier_gate_bit <= carrier_gate_buffer_bit; // RL7
  end
  // carrier is high through the compare A phase
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      carrier_output_pin <= 1'b0;
    else if (remote_output_enable && carrier_gate_bit &&
             carrier_timer_enable)
      carrier_output_pin <= ~use_b; // RL9
    else
      carrier_output_pin <= 1'b0; // RL17
  end

  // ----------------------------------------------------------------
  // event counters
  // ----------------------------------------------------------------
  assign pacing_cfg = make_cfg(pacing_mode_control, pacing_clock_select,
                               pacing_compare_register); // RL2
  assign evt0_cfg   = make_cfg(event_timer_mode_control,
                               count_clock_select_register,
                               event_timer_compare);

  cpt_event_counter u_pacing (
    .clk       (clk),
    .rst_n     (rst_n),
    .cfg       (pacing_cfg),
    .prescale  (prescale),
    .level_set (pace_lvs),
    .level_clr (pace_lvr),
    .count     (pacing_count),
    .match     (pacing_match_irq),
    .pin       (pacing_output_pin)
  );

  cpt_event_counter u_evt0 (
    .clk       (clk),
    .rst_n     (rst_n),
    .cfg       (evt0_cfg),
    .prescale  (prescale),
    .level_set (evt0_lvs),
    .level_clr (evt0_lvr),
    .count     (evt0_count),
    .match     (evt0_match),
    .pin       (event_timer_output_pin)
  );

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // bit order follows the status layout: evt0, strobe, pacing, carrier
  assign irq_events = {evt0_match, synced_data_strobe, pacing_match_irq,
                       carrier_match_irq};
  assign irq_clear = (wr_fire && wr_to(req, `CPT_OFS_IRQ_CLEAR)) ?
                     req.writedata[`CPT_IRQ_BITS-1:0] : '0;
  // a new event beats a clear in the same cycle
  assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_status <= '0;
    else
      irq_status <= next_irq_status;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_enable <= '0;
    else if (wr_fire && wr_to(req, `CPT_OFS_IRQ_ENABLE))
      irq_enable <= req.writedata[`CPT_IRQ_BITS-1:0];
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(next_irq_status & irq_enable);
  end

endmodule

// File: verification/cpt_monitor.sv
`timescale 1ns/1ps
`include "cpt_cfg.svh"

// ----------------------------------------------------------------
// bus handshake, carrier pin and irq mask checks
// ----------------------------------------------------------------
module cpt_monitor
  import cpt_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        carrier_output_pin,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] cmp_a;
  logic       car_on;
  logic       irq_on;
  logic [1:0] off_cnt;
  logic [1:0] mask_cnt;
  logic       wr_ack;

  assign wr_ack = avs_write && !avs_waitrequest;

  // shadows follow writes at the edge where they land
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cmp_a  <= `CPT_RST_CMP;
      car_on <= 1'b0;
      irq_on <= 1'b0;
    end
    else if (wr_ack)
    begin
      case (avs_address)
        `CPT_OFS_CMP_A:        cmp_a  <= avs_writedata[7:0];
        `CPT_OFS_CARRIER_MODE: car_on <= avs_writedata[`CPT_BIT_ENABLE];
        `CPT_OFS_IRQ_ENABLE:   irq_on <= |avs_writedata[3:0];
        default:               cmp_a  <= cmp_a;
      endcase
    end
  end

  // pin and irq are registered: allow three cycles of lag
  always_ff @(posedge clk)
  begin
    if (!rst_n || car_on)
      off_cnt <= 2'd0;
    else if (off_cnt != 2'd3)
      off_cnt <= off_cnt + 2'd1;
    if (!rst_n || irq_on)
      mask_cnt <= 2'd0;
    else if (mask_cnt != 2'd3)
      mask_cnt <= mask_cnt + 2'd1;
  end

  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_rd_req(logic [7:0] a);
    avs_read && avs_waitrequest && avs_address == a;
  endsequence

  a_wait_answer: assert property (s_req_wait |=> !avs_waitrequest)
    else $error("no bus answer");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("long answer");
  a_wait_idle: assert property
    (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("stray answer");
  a_read_holds: assert property
    (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("readdata moved");
  a_unmapped_zero: assert property
    (s_rd_req(8'h40) |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_clear_reads_zero: assert property
    (s_rd_req(`CPT_OFS_IRQ_CLEAR) |=> avs_readdata == 32'h0)
    else $error("clear reg not zero");
  a_cmp_readback: assert property
    (s_rd_req(`CPT_OFS_CMP_A) |=> avs_readdata == {24'h0, cmp_a})
    else $error("compare A readback wrong");
  a_carrier_off: assert property (off_cnt == 2'd3 |-> !carrier_output_pin)
    else $error("carrier pin while off");
  a_irq_masked: assert property (mask_cnt == 2'd3 |-> !irq)
    else $error("irq while masked");
endmodule

bind cpt_top cpt_monitor mon
(
  .clk                (clk),
  .rst_n              (rst_n),
  .avs_address        (avs_address),
  .avs_read           (avs_read),
  .avs_write          (avs_write),
  .avs_writedata      (avs_writedata),
  .avs_readdata       (avs_readdata),
  .avs_waitrequest    (avs_waitrequest),
  .carrier_output_pin (carrier_output_pin),
  .irq                (irq)
);

// File: verification/cpt_remote_rx.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// receiver side: measures high and low runs of the carrier pin
// ----------------------------------------------------------------
module cpt_remote_rx
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        carrier_in,
  output logic [15:0]      hi_len,
  output logic [15:0]      lo_len
);
  logic [15:0] run;
  logic        prev;

  // last completed run only, so start-up pulses drop out
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      run    <= 16'h0;
      prev   <= 1'b0;
      hi_len <= 16'h0;
      lo_len <= 16'h0;
    end
    else if (carrier_in == prev)
      run <= run + 16'h1;
    else
    begin
      if (prev)
        hi_len <= run;
      else
        lo_len <= run;
      run  <= 16'h1;
      prev <= carrier_in;
    end
  end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "cpt_cfg.svh"

module tb_top;
  logic        clk;
  logic        rst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        car_pin;
  logic        pace_pin;
  logic        evt_pin;
  logic        irq;
  logic [15:0] hi_len;
  logic [15:0] lo_len;
  logic [31:0] rd;
  logic [15:0] cnt;
  logic [15:0] exp_w;
  logic [7:0]  c;
  logic [7:0]  ofs [3];
  int          n_errors;
  int          total_checks;
  int          shadow [int];

  cpt_top dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .carrier_output_pin(car_pin),
    .pacing_output_pin(pace_pin), .event_timer_output_pin(evt_pin),
    .irq(irq));

  cpt_remote_rx rx (.clk(clk), .rst_n(rst_n), .carrier_in(car_pin),
    .hi_len(hi_len), .lo_len(lo_len));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check_reg(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_wave(input string nm, input logic [15:0] e,
                            input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // avalon master: hold until waitrequest sampled low
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      n_errors++;
      $display("Error bus answer at %h expected 0 seen 1", a);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    shadow[a] = {24'h0, d[7:0]};
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check_reg(nm, e, rd);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic count_pin(input int n, input logic which);
    cnt = 16'h0;
    repeat (n)
    begin
      @(posedge clk);
      cnt = cnt + 16'(which ? evt_pin : car_pin);
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    $display("Error watchdog expected done seen running");
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    n_errors = 0;
    total_checks = 0;
    ofs = '{`CPT_OFS_CMP_A, `CPT_OFS_CMP_B, `CPT_OFS_EVT0_CMP};
    void'($urandom(32'h5166c7a0));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk("cmp_a", `CPT_OFS_CMP_A, 32'hFF);
    rd_chk("pace_cmp", `CPT_OFS_PACE_CMP, 32'hFF);
    rd_chk("status", `CPT_OFS_IRQ_STATUS, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(ofs[i], $urandom);
      rd_chk("readback", ofs[i], shadow[ofs[i]]);
    end
    // carrier: A phase 3 ticks high, B phase 4 ticks low
    wr(`CPT_OFS_CMP_A, 32'h2);
    wr(`CPT_OFS_CMP_B, 32'h3);
    wr(`CPT_OFS_CARRIER_CTRL, 32'h5);
    wr(`CPT_OFS_PACE_CLK, 32'h0);
    wr(`CPT_OFS_PACE_CMP, 32'h4);
    wr(`CPT_OFS_PACE_MODE, 32'h80);
    for (int k = 0; k < 2; k++)
    begin
      wr(`CPT_OFS_CARRIER_MODE, 32'h0);
      wr(`CPT_OFS_CARRIER_MODE, 32'h80 | k);
      cyc(100);
      rd_chk("gate_on", `CPT_OFS_CARRIER_CTRL, 32'h7);
      check_wave("carrier_high", 16'(3 << k), hi_len);
      check_wave("carrier_low", 16'(4 << k), lo_len);
    end
    rd_chk("status", `CPT_OFS_IRQ_STATUS, 32'h7);
    wr(`CPT_OFS_CARRIER_CTRL, 32'h4);
    cyc(40);
    rd_chk("gate_off", `CPT_OFS_CARRIER_CTRL, 32'h4);
    count_pin(60, 1'b0);
    check_wave("gated_pin", 16'h0, cnt);
    // interrupt: mask, raise, clear
    wr(`CPT_OFS_CARRIER_MODE, 32'h0);
    wr(`CPT_OFS_PACE_MODE, 32'h0);
    cyc(4);
    check_wave("irq_masked", 16'h0, {15'h0, irq});
    wr(`CPT_OFS_IRQ_ENABLE, 32'h1);
    cyc(4);
    check_wave("irq_raised", 16'h1, {15'h0, irq});
    wr(`CPT_OFS_IRQ_CLEAR, 32'h1);
    cyc(4);
    check_wave("irq_cleared", 16'h0, {15'h0, irq});
    rd_chk("status", `CPT_OFS_IRQ_STATUS, 32'h6);
    wr(`CPT_OFS_IRQ_CLEAR, 32'hF);
    rd_chk("status", `CPT_OFS_IRQ_STATUS, 32'h0);
    rd_chk("clear_reg", `CPT_OFS_IRQ_CLEAR, 32'h0);
    // pwm on counter 0, both polarities and two count clocks
    for (int i = 0; i < 4; i++)
    begin
      c = 8'(1 + $urandom % 254);
      wr(`CPT_OFS_EVT0_CLK, i & 1);
      wr(`CPT_OFS_EVT0_CMP, c);
      wr(`CPT_OFS_EVT0_MODE, 32'hC1 | ((i >> 1) << 1));
      cyc(600);
      count_pin(256 << (i & 1), 1'b1);
      exp_w = (i >> 1) ? 16'(256 - c) : 16'(c);
      check_wave("pwm_active", exp_w << (i & 1), cnt);
    end
    wr(`CPT_OFS_EVT0_MODE, 32'h09);
    cyc(3);
    check_wave("level_set", 16'h1, {15'h0, evt_pin});
    wr(`CPT_OFS_EVT0_MODE, 32'h05);
    cyc(3);
    check_wave("level_reset", 16'h0, {15'h0, evt_pin});
    wr(`CPT_OFS_PACE_MODE, 32'h08);
    cyc(3);
    check_wave("pace_level", 16'h1, {15'h0, pace_pin});
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h40, 32'h0);
    tally_and_finish;
  end
endmodule
